// ---- rtl/src_pkg.sv ----
// package for the sample rate configuration controller
// assumes a 4-phase register write port toward the sensor's serial engine
`default_nettype none
package src_pkg;
  // sensor register map
  localparam logic [7:0] DEV_MODE = 8'h10;
  localparam logic [7:0] DEV_WAKE_RATE = 8'h11;
  localparam logic [7:0] DEV_WATCH_IDLE_RATE = 8'h12;
  localparam logic [7:0] DEV_RANGE = 8'h15;
  localparam logic [7:0] DEV_FIFO = 8'h16;
  localparam logic [7:0] DEV_POWER_CFG = 8'h1c;
  localparam logic [7:0] DEV_INDIRECT = 8'h29;
  localparam logic [7:0] WAKE_RATE_RESET = 8'h00;
  localparam logic [7:0] WATCH_IDLE_RESET = 8'h00;
  // mode select field codes
  localparam logic [7:0] MODE_STANDBY = 8'h01;
  localparam logic [7:0] MODE_CONTINUOUS_WAKE = 8'h05;
  // power configuration values for wake rates
  localparam logic [7:0] PWR_ULP = 8'h03;
  localparam logic [7:0] PWR_LP = 8'h00;
  localparam logic [7:0] PWR_PREC = 8'h04;
  // fast-rate unlock values
  localparam logic [3:0] FAST_CODE = 4'hf;
  localparam logic [7:0] PTR_SETUP = 8'h10;
  localparam logic [7:0] SETUP1 = 8'h03;
  localparam logic [7:0] PTR_SETUP2 = 8'h20;
  localparam logic [7:0] SETUP3 = 8'h01;
  localparam logic [7:0] PTR_VAL1 = 8'h40;
  localparam logic [7:0] PTR_VAL2 = 8'h50;
  localparam logic [7:0] VAL1_ULP = 8'h52;
  localparam logic [7:0] VAL1_LP = 8'h72;
  localparam logic [7:0] VAL1_PREC = 8'h32;
  localparam logic [7:0] VAL2_ULP = 8'h01;
  localparam logic [7:0] VAL2_LP = 8'h02;
  localparam logic [7:0] VAL2_PREC = 8'h12;
  localparam logic [7:0] APPLY_FAST = 8'h0f;
  // sequence lengths (last step index)
  localparam logic [3:0] LAST_PLAIN = 4'h2;
  localparam logic [3:0] LAST_FAST = 4'he;
  // software register offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_RATES = 12'h004;
  localparam logic [11:0] OFF_SETUP = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  // field positions
  localparam int CTRL_CODE_LSB = 0;
  localparam int CTRL_PMODE_LSB = 4;
  localparam int CTRL_START_BIT = 8;
  localparam int RATES_WATCH_LSB = 0;
  localparam int RATES_TICK_LSB = 4;
  localparam int SETUP_FIFO_LSB = 8;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_STEP_LSB = 4;
  // power mode selector encodings held by software
  localparam logic [1:0] PSEL_ULP = 2'h0;
  localparam logic [1:0] PSEL_LP = 2'h1;
  localparam logic [1:0] PSEL_PREC = 2'h2;
  localparam logic [7:0] RANGE_RESET = 8'h04;
  localparam logic [7:0] FIFO_RESET = 8'h5d;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } src_write_s;

  typedef enum logic [1:0] {
    SRC_IDLE = 2'b00,
    SRC_ISSUE = 2'b01,
    SRC_WAIT_ACK = 2'b11,
    SRC_WAIT_REL = 2'b10
  } src_state_e;
endpackage
`default_nettype wire

// ---- rtl/src_rate_ctrl.sv ----
// host controller that programs the sensor's sample rate registers
// assumes a serial engine outside that performs one register write per
// 4-phase handshake (devReq held until devAck, then released)
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - the upper four bits of the wake rate register are written as zero, except for the unlock pointers 0x10, 0x20, 0x40 and 0x50.
// - power configuration 0x03 is ultra-low-power, 0x00 low-power, 0x04 precision.
// - the watch rates read the power field with their own encoding, separate from the wake rates.
// - bit 4 of the second rate register is always written as zero.
// - code 0x0F needs the unlock sequence, every other code is a plain write.
// - the unlock sequence enters standby, writes range, FIFO and power configuration.
// - writing 0x10 to the wake rate register points indirect writes at hidden rate settings.
// - after that pointer 0x03 is written to the indirect data register.
// - then 0x20 goes to the wake rate register and 0x01 to the indirect data register.
// - pointer 0x40 with value 1, pointer 0x50 with value 2, apply 0x0F, then continuous wake.
module src_rate_ctrl (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic devReq,
  output src_pkg::src_write_s devWrite,
  input wire logic devAck
);

  // ==========================================================
  // software registers
  logic [3:0] wakeCode;
  logic [1:0] powerSel;
  logic [3:0] watchCode;
  logic [2:0] tickCode;
  logic [7:0] rangeVal;
  logic [7:0] fifoVal;
  logic done;
  logic fast;
  logic [3:0] step;
  src_pkg::src_state_e state;
  src_pkg::src_state_e next_state;

  wire apbAccess = psel & penable & pready;
  wire apbPending = psel & penable & ~pready;
  wire hitCtrl = paddr == src_pkg::OFF_CTRL;
  wire hitRates = paddr == src_pkg::OFF_RATES;
  wire hitSetup = paddr == src_pkg::OFF_SETUP;
  wire hitStatus = paddr == src_pkg::OFF_STATUS;
  wire mapped = hitCtrl | hitRates | hitSetup | hitStatus;
  wire busy = state != src_pkg::SRC_IDLE;
  wire wrCtrl = apbAccess & pwrite & hitCtrl & ~busy;
  wire startCmd = wrCtrl & pwdata[src_pkg::CTRL_START_BIT];
  wire wrRates = apbAccess & pwrite & hitRates & ~busy;
  wire wrSetup = apbAccess & pwrite & hitSetup & ~busy;

  // ==========================================================
  // power configuration decode, wake encoding only
  function automatic logic [7:0] pick3(input logic [1:0] sel, input logic [7:0] u,
                                       input logic [7:0] l, input logic [7:0] p);
    unique case (sel)
      src_pkg::PSEL_ULP: pick3 = u;
      src_pkg::PSEL_PREC: pick3 = p;
      default: pick3 = l;
    endcase
  endfunction

  // the watch rates decode this field differently in the sensor; the host only
  // sends the wake encoding, the watch code is forwarded raw
  wire [7:0] powerCfg = pick3(powerSel, src_pkg::PWR_ULP, src_pkg::PWR_LP, src_pkg::PWR_PREC);
  wire [7:0] val1 = pick3(powerSel, src_pkg::VAL1_ULP, src_pkg::VAL1_LP, src_pkg::VAL1_PREC);
  wire [7:0] val2 = pick3(powerSel, src_pkg::VAL2_ULP, src_pkg::VAL2_LP, src_pkg::VAL2_PREC);
  wire [7:0] wakeByte = {4'h0, wakeCode};
  wire [7:0] watchByte = {tickCode, 1'b0, watchCode};

  // ==========================================================
  // rate readback: what the stored settings give once they are sent
  // nominal wake output rate in Hz; 0 marks a code the sensor lacks in that mode
  // the sensor keeps its own table, this copy only lets software read the result
  function automatic logic [10:0] wakeHz(input logic [1:0] sel, input logic [3:0] code);
    unique case (sel)
      src_pkg::PSEL_ULP: begin
        unique case (code)
          4'h6: wakeHz = 11'h019;
          4'h7: wakeHz = 11'h032;
          4'h8: wakeHz = 11'h064;
          4'h9: wakeHz = 11'h0be;
          4'ha: wakeHz = 11'h17c;
          4'hb: wakeHz = 11'h2ee;
          4'hc: wakeHz = 11'h44c;
          4'hf: wakeHz = 11'h514;
          default: wakeHz = 11'h000;
        endcase
      end
      src_pkg::PSEL_PREC: begin
        unique case (code)
          4'h5: wakeHz = 11'h00e;
          4'h6: wakeHz = 11'h01c;
          4'h7: wakeHz = 11'h037;
          4'h8: wakeHz = 11'h050;
          4'hf: wakeHz = 11'h064;
          default: wakeHz = 11'h000;
        endcase
      end
      default: begin
        // low-power, also for the spare selector value
        unique case (code)
          4'h5: wakeHz = 11'h00e;
          4'h6: wakeHz = 11'h01c;
          4'h7: wakeHz = 11'h036;
          4'h8: wakeHz = 11'h069;
          4'h9: wakeHz = 11'h0d2;
          4'ha: wakeHz = 11'h190;
          4'hb: wakeHz = 11'h258;
          4'hf: wakeHz = 11'h2ee;
          default: wakeHz = 11'h000;
        endcase
      end
    endcase
  endfunction

  // every power value sent leaves the watch bits of the power field at 000, so the
  // sensor runs watch rates in its low-power column whatever the wake mode;
  // result in tenths of Hz, 0 marks a code with no rate
  function automatic logic [12:0] watchDeciHz(input logic [3:0] code);
    unique case (code)
      4'h0: watchDeciHz = 13'h0046;
      4'h1: watchDeciHz = 13'h0004;
      4'h2: watchDeciHz = 13'h0008;
      4'h3: watchDeciHz = 13'h000f;
      4'h4: watchDeciHz = 13'h0046;
      4'h5: watchDeciHz = 13'h008c;
      4'h6: watchDeciHz = 13'h0118;
      4'h7: watchDeciHz = 13'h021c;
      4'h8: watchDeciHz = 13'h041a;
      4'h9: watchDeciHz = 13'h0834;
      4'ha: watchDeciHz = 13'h0fa0;
      4'hb: watchDeciHz = 13'h1770;
      default: watchDeciHz = 13'h0000;
    endcase
  endfunction

  wire [10:0] wakeRateHz = wakeHz(powerSel, wakeCode);
  wire [12:0] watchRate = watchDeciHz(watchCode);

  // ==========================================================
  // write sequences
  function automatic src_pkg::src_write_s stepWrite(input logic isFast, input logic [3:0] idx,
                                                    input logic [7:0] pw, input logic [7:0] wb,
                                                    input logic [7:0] sb, input logic [7:0] rg,
                                                    input logic [7:0] ff, input logic [7:0] v1,
                                                    input logic [7:0] v2);
    stepWrite = '{addr: src_pkg::DEV_WATCH_IDLE_RATE, data: sb};
    if (!isFast) begin
      // plain path: power config first so the rate code is read in its mode
      unique case (idx)
        4'h0: stepWrite = '{addr: src_pkg::DEV_POWER_CFG, data: pw};
        4'h1: stepWrite = '{addr: src_pkg::DEV_WAKE_RATE, data: wb};
        default: stepWrite = '{addr: src_pkg::DEV_WATCH_IDLE_RATE, data: sb};
      endcase
    end else begin
      unique case (idx)
        4'h0: stepWrite = '{addr: src_pkg::DEV_MODE, data: src_pkg::MODE_STANDBY};
        4'h1: stepWrite = '{addr: src_pkg::DEV_RANGE, data: rg};
        4'h2: stepWrite = '{addr: src_pkg::DEV_FIFO, data: ff};
        4'h3: stepWrite = '{addr: src_pkg::DEV_POWER_CFG, data: pw};
        4'h4: stepWrite = '{addr: src_pkg::DEV_WAKE_RATE, data: src_pkg::PTR_SETUP};
        4'h5: stepWrite = '{addr: src_pkg::DEV_INDIRECT, data: src_pkg::SETUP1};
        4'h6: stepWrite = '{addr: src_pkg::DEV_WAKE_RATE, data: src_pkg::PTR_SETUP2};
        4'h7: stepWrite = '{addr: src_pkg::DEV_INDIRECT, data: src_pkg::SETUP3};
        4'h8: stepWrite = '{addr: src_pkg::DEV_WAKE_RATE, data: src_pkg::PTR_VAL1};
        4'h9: stepWrite = '{addr: src_pkg::DEV_INDIRECT, data: v1};
        4'ha: stepWrite = '{addr: src_pkg::DEV_WAKE_RATE, data: src_pkg::PTR_VAL2};
        4'hb: stepWrite = '{addr: src_pkg::DEV_INDIRECT, data: v2};
        4'hc: stepWrite = '{addr: src_pkg::DEV_WAKE_RATE, data: src_pkg::APPLY_FAST};
        4'hd: stepWrite = '{addr: src_pkg::DEV_MODE, data: src_pkg::MODE_CONTINUOUS_WAKE};
        default: stepWrite = '{addr: src_pkg::DEV_WATCH_IDLE_RATE, data: sb};
      endcase
    end
  endfunction

  wire src_pkg::src_write_s curWrite = stepWrite(fast, step, powerCfg, wakeByte, watchByte,
                                                 rangeVal, fifoVal, val1, val2);
  wire [3:0] lastStep = fast ? src_pkg::LAST_FAST : src_pkg::LAST_PLAIN;
  // only the wake code has an unlock run; a watch code of 0xF is sent as a plain
  // write, so software must not ask for it
  wire isFastCode = wakeCode == src_pkg::FAST_CODE;

  // ==========================================================
  // acknowledge synchroniser, the engine runs on its own timing
  logic ackMeta;
  logic ackSync;
  always_ff @(posedge clk) begin
    ackMeta <= srst ? 1'b0 : devAck;
    ackSync <= srst ? 1'b0 : ackMeta;
  end

  // ==========================================================
  // sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      src_pkg::SRC_IDLE: if (startCmd) next_state = src_pkg::SRC_ISSUE;
      src_pkg::SRC_ISSUE: next_state = src_pkg::SRC_WAIT_ACK;
      src_pkg::SRC_WAIT_ACK: if (ackSync) next_state = src_pkg::SRC_WAIT_REL;
      src_pkg::SRC_WAIT_REL: begin
        // a new request only after the engine drops its ack, so no write is doubled
        if (!ackSync) next_state = (step == lastStep) ? src_pkg::SRC_IDLE : src_pkg::SRC_ISSUE;
      end
    endcase
  end

  wire stepDone = state == src_pkg::SRC_WAIT_REL && !ackSync;

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= src_pkg::SRC_IDLE;
      step <= 4'h0;
      fast <= 1'b0;
      done <= 1'b0;
      devReq <= 1'b0;
      devWrite <= '0;
    end else begin
      state <= next_state;
      // the write is loaded in ISSUE, a cycle after start, so the step, mode and
      // codes stored by the start write itself are the ones that go out
      devReq <= next_state == src_pkg::SRC_WAIT_ACK;
      if (state == src_pkg::SRC_ISSUE) devWrite <= curWrite;
      if (startCmd) begin
        step <= 4'h0;
        fast <= pwdata[src_pkg::CTRL_CODE_LSB +: 4] == src_pkg::FAST_CODE;
        done <= 1'b0;
      end else if (stepDone) begin
        step <= (step == lastStep) ? 4'h0 : step + 4'h1;
        done <= step == lastStep;
      end
    end
  end

  // ==========================================================
  // software register storage
  always_ff @(posedge clk) begin
    if (srst) begin
      wakeCode <= src_pkg::WAKE_RATE_RESET[3:0];
      powerSel <= src_pkg::PSEL_LP;
      watchCode <= src_pkg::WATCH_IDLE_RESET[3:0];
      tickCode <= src_pkg::WATCH_IDLE_RESET[7:5];
      rangeVal <= src_pkg::RANGE_RESET;
      fifoVal <= src_pkg::FIFO_RESET;
    end else begin
      if (wrCtrl) begin
        wakeCode <= pwdata[src_pkg::CTRL_CODE_LSB +: 4];
        powerSel <= pwdata[src_pkg::CTRL_PMODE_LSB +: 2];
      end
      if (wrRates) begin
        watchCode <= pwdata[src_pkg::RATES_WATCH_LSB +: 4];
        tickCode <= pwdata[src_pkg::RATES_TICK_LSB +: 3];
      end
      if (wrSetup) begin
        rangeVal <= pwdata[7:0];
        fifoVal <= pwdata[src_pkg::SETUP_FIFO_LSB +: 8];
      end
    end
  end

  // ==========================================================
  // apb answer, one wait state so every output is registered
  logic [31:0] readMux;
  always_comb begin
    readMux = 32'h0;
    if (hitCtrl) readMux = {26'h0, powerSel, wakeCode};
    // decoded rates ride in the upper half so the stored fields keep their places
    if (hitRates) readMux = {3'h0, watchRate, 9'h0, tickCode, watchCode};
    if (hitSetup) readMux = {16'h0, fifoVal, rangeVal};
    if (hitStatus) readMux = {5'h0, wakeRateHz, 7'h0, isFastCode, step, 2'h0, done, busy};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apbPending;
      pslverr <= apbPending & ~mapped;
      if (apbPending) prdata <= pwrite ? 32'h0 : readMux;
    end
  end

endmodule
`default_nettype wire

// ---- tb/src_dev_model.sv ----
// sensor model: takes one register write per handshake and logs it
// assumes the 4-phase port of src_rate_ctrl; slow adds ack latency
`timescale 1ns/10ps
`default_nettype none
module src_dev_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic devReq,
  input wire src_pkg::src_write_s devWrite,
  output logic devAck,
  output logic [7:0] wakeRate,
  output logic [7:0] watchIdle,
  output logic [5:0] nWrites
);
  src_pkg::src_write_s log [64];
  logic [2:0] dly;
  always_ff @(posedge clk) begin
    if (srst) begin
      devAck <= 1'b0;
      dly <= 3'h0;
      nWrites <= 6'h0;
      wakeRate <= 8'h00;
      watchIdle <= 8'h00;
    end else if (!devReq) begin
      devAck <= 1'b0;
      dly <= slow ? 3'h5 : 3'h0;
    end else if (!devAck && dly != 3'h0) begin
      dly <= dly - 3'h1;
    end else if (!devAck) begin
      devAck <= 1'b1;
      log[nWrites] <= devWrite;
      nWrites <= nWrites + 6'h1;
      if (devWrite.addr == 8'h11) wakeRate <= devWrite.data;
      if (devWrite.addr == 8'h12) watchIdle <= devWrite.data;
    end
  end
endmodule
`default_nettype wire

// ---- tb/src_rate_ctrl_chk.sv ----
// checker for the rate controller bus and sensor write ports
// bound to src_rate_ctrl; sees its ports only
`timescale 1ns/10ps
`default_nettype none
module src_rate_ctrl_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic devReq,
  input wire src_pkg::src_write_s devWrite,
  input wire logic devAck
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  wire logic mapped;
  wire logic ptr;
  assign mapped = paddr[11:4] == 8'h00 && paddr[1:0] == 2'b00;
  // pointer values are the one legal exception to a clear upper nibble
  assign ptr = devWrite.data inside {8'h10, 8'h20, 8'h40, 8'h50};
  // ==========================================
  // bus side
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  a_err_decode: assert property (pready |-> pslverr == !mapped) else $error("pslverr wrong");
  a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0) else $error("prdata on write");
  // ==========================================
  // sensor write side
  a_wake_upper: assert property (devReq && devWrite.addr == 8'h11 && !ptr |-> devWrite.data[7:4] == 4'h0)
    else $error("wake rate upper bits set");
  a_idle_bit4: assert property (devReq && devWrite.addr == 8'h12 |-> !devWrite.data[4])
    else $error("bit 4 written as one");
  a_pwr_value: assert property (devReq && devWrite.addr == 8'h1c |->
    devWrite.data inside {8'h00, 8'h03, 8'h04}) else $error("power value illegal");
  a_mode_code: assert property (devReq && devWrite.addr == 8'h10 |-> devWrite.data inside {8'h01, 8'h05})
    else $error("mode code illegal");
  a_req_hold: assert property (devReq && !devAck |=> devReq) else $error("request dropped early");
  a_data_stable: assert property (devReq ##1 devReq |-> $stable(devWrite)) else $error("write moved");
  a_req_release: assert property ($rose(devAck) |-> ##[1:4] !devReq) else $error("request stuck");
  a_req_gap: assert property ($fell(devAck) |-> !devReq [*2]) else $error("request too soon");
endmodule
bind src_rate_ctrl src_rate_ctrl_chk chk (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .devReq(devReq), .devWrite(devWrite), .devAck(devAck));
`default_nettype wire

// ---- tb/src_rate_ctrl_tb.sv ----
// self-checking bench for the sample rate controller
// APB driven by hand; src_dev_model answers the sensor port
`timescale 1ns/10ps
`default_nettype none
module src_rate_ctrl_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic slow = 1'b0;
  logic devAck, devReq, pready, pslverr, e;
  logic [31:0] prdata, q;
  src_pkg::src_write_s devWrite;
  int n_errors = 0;
  int n_compared = 0;
  int b;
  logic [7:0] pwv [3] = '{8'h03, 8'h00, 8'h04};
  logic [7:0] v1 [3] = '{8'h52, 8'h72, 8'h32};
  logic [7:0] v2 [3] = '{8'h01, 8'h02, 8'h12};
  logic [10:0] hz [3] = '{11'h000, 11'h01c, 11'h037};
  logic [10:0] hf [3] = '{11'h514, 11'h2ee, 11'h064};
  always #10 clk = ~clk;
  src_rate_ctrl dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .devReq(devReq), .devWrite(devWrite), .devAck(devAck));
  src_dev_model model (.clk(clk), .srst(srst), .slow(slow), .devReq(devReq), .devWrite(devWrite),
    .devAck(devAck), .wakeRate(), .watchIdle(), .nWrites());
  // ==========================================
  // shared tasks
  task automatic stop_test;
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
      n_errors++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // polls status until done; bounded so a stuck sequence cannot hang
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h00c, 32'h0);
      n++;
    end while (q[1] !== 1'b1 && n < 300);
    if (n >= 300) begin
      n_errors++;
      stop_test();
    end
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h10);
    apb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h5d04);
    chk({model.wakeRate, model.watchIdle}, 32'h0);
    apb(1'b1, 12'h004, 32'h5b);
    apb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h1770005b);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h00460000);
  endtask
  task automatic t_plain;
    for (int m = 0; m < 3; m++) begin
      b = model.nWrites;
      apb(1'b1, 12'h004, 32'h5b);
      apb(1'b1, 12'h000, 32'h100 | (m << 4) | (5 + m));
      wait_done();
      chk(q[26:16], hz[m]);
      chk(model.log[b], {8'h1c, pwv[m]});
      chk(model.log[b + 1], 32'h1105 + m);
      chk(model.log[b + 2], 32'h12ab);
    end
  endtask
  task automatic t_fast;
    logic [15:0] s [15];
    slow <= 1'b1;
    for (int m = 0; m < 3; m++) begin
      s = '{16'h1001, 16'h1508, 16'h163c, {8'h1c, pwv[m]}, 16'h1110, 16'h2903, 16'h1120, 16'h2901,
        16'h1140, {8'h29, v1[m]}, 16'h1150, {8'h29, v2[m]}, 16'h110f, 16'h1005, 16'h12ab};
      b = model.nWrites;
      apb(1'b1, 12'h008, 32'h3c08);
      apb(1'b1, 12'h000, 32'h10f | (m << 4));
      apb(1'b1, 12'h000, 32'h007);
      wait_done();
      chk(q[26:16], hf[m]);
      for (int i = 0; i < 15; i++)
        chk(model.log[b + i], s[i]);
      apb(1'b0, 12'h000, 32'h0);
      chk(q, 32'h0f | (m << 4));
    end
    chk(model.wakeRate, 32'h0f);
    slow <= 1'b0;
  endtask
  task automatic t_unmapped;
    apb(1'b0, 12'h010, 32'h0);
    chk(q, 32'h0);
    chk(32'(e), 32'h1);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_plain();
    t_fast();
    t_unmapped();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
